// >>> rtl/vfd_scan_control_decoder.sv
// serial word receiver, control decoder and multiplex scan timing
// assumes serial pins are asynchronous to i_sys_clk and are synchronised here
// What this block does
// R01: words arrive msb first on the serial link; load strobe hands one over.
// R02: ninth bit zero means display data; low eight bits go to the buffer.
// R03: pointer increments after each data store; wraps at programmed digit count.
// R04: reset turns drivers off, clears duty and pointer, 32 digits, 64 cycles, halted.
// R05: pointer word loads low five bits; codes D0-DF are ignored.
// R06: digit count word loads low five bits; zero means 32 grids.
// R07: scan strobes grids in order from position zero to the last counted one.
// R08: counts above sixteen add phantom slots, up to 32 slots in total.
// R09: during phantom slots all sixteen real strobes stay off.
// R10: slot length is 8, 16, 32 or 64 internal cycles of half a period.
// R11: each slot ends with at least three all-off cycles.
// R12: duty word stores six bits; on-time is value minus two, clamped.
// R13: word with upper three data bits zero loads the control register.
// R14: time field 00=64, 01=16, 10=32, 11=8 cycles per grid.
// R15: digit time is 64 after reset until the host changes it.
// R16: middle bit picks 16 or 8 digit layout; top two bits the decoder mode.
// R17: 16-digit layout: word n decoded onto segments while strobe n is on.
// R18: 8-digit layout: word 2k direct, word 2k+1 decoded, on strobe k.
// R19: bypass drives each data bit onto two adjacent segment outputs.
// R20: mode 10 uses codes 64 to 127, mode 11 uses codes 0 to 63.
// R21: in 64-code modes the top two data bits drive the last two segments.
// R22: the host never selects the reserved decoder mode 01.
// R23: control words take effect at the next slot boundary, or at once while halted.
`timescale 1ns/100ps
`default_nettype none
module vfd_scan_control_decoder #(
   parameter int                CYCLE_TICKS = vfd_scan_pkg::CYCLE_TICKS,
   parameter int                FIFO_DEPTH  = vfd_scan_pkg::FIFO_WORDS,
   parameter logic [128*14-1:0] GLYPH_TABLE = '0
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_serial_clk,
   input  wire logic        i_serial_data,
   input  wire logic        i_word_load_strobe,
   output logic      [7:0]  o_grid_strobes,
   output logic      [7:0]  o_direct_outputs,
   output logic      [15:0] o_decoded_segment_outputs,
   output logic             o_word_ready
);
   // prescaler width; counts 0 up to CYCLE_TICKS-1
   localparam int TW = $clog2(CYCLE_TICKS);
   localparam logic [TW-1:0] TICK_LAST = TW'(CYCLE_TICKS - 1);

   // pin synchronisers: bit 0 clock, bit 1 data, bit 2 load
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   logic [2:0] pin_prev_reg;
   logic       sclk_rise;
   logic       load_rise;

   logic [8:0] shift_reg;
   logic       fifo_in_ready;
   logic       fifo_out_valid;
   logic       fifo_out_ready;
   logic [8:0] fifo_out_data;

   logic [8:0] pend_reg;
   logic       pend_valid_reg;
   logic       apply;

   logic [4:0] ptr_reg;
   logic [4:0] count_reg;
   logic [5:0] duty_reg;
   logic [4:0] ctrl_reg;
   logic [7:0] buf_mem [vfd_scan_pkg::BUF_WORDS];

   vfd_scan_pkg::scan_state_t state_reg;
   vfd_scan_pkg::scan_state_t state_next;

   logic [TW-1:0] tick_reg;
   logic          cyc_tick;
   logic [5:0]    cyc_reg;
   logic [5:0]    slot_last;
   logic          slot_end;
   logic [4:0]    slot_reg;
   logic [4:0]    slot_inc;
   logic [4:0]    ptr_inc;
   logic [5:0]    on_time;
   logic          drive_on;

   logic [7:0]  dec_data;
   logic [15:0] dec_segments;
   logic [7:0]  grid_next;
   logic [7:0]  direct_next;
   logic [15:0] seg_next;
   logic [15:0] strobe16;

   // cycles per grid from the time field
   function automatic logic [5:0] slot_last_of(input logic [1:0] code);
      unique case (code)
         2'h0: slot_last_of = 6'h3F; // 64 cycles [R14]
         2'h1: slot_last_of = 6'h0F; // 16 cycles [R14]
         2'h2: slot_last_of = 6'h1F; // 32 cycles [R14]
         2'h3: slot_last_of = 6'h07; // 8 cycles [R14]
      endcase
   endfunction : slot_last_of

   // two flip-flops on every pin, a third for edge finding
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         pin_meta_reg <= 3'h0;
         pin_sync_reg <= 3'h0;
         pin_prev_reg <= 3'h0;
      end else begin
         pin_meta_reg <= {i_word_load_strobe, i_serial_data, i_serial_clk};
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // rising edges of the synchronised link clock and load pins
   assign sclk_rise = pin_sync_reg[0] && !pin_prev_reg[0];
   assign load_rise = pin_sync_reg[2] && !pin_prev_reg[2];

   // serial shift, msb first
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         shift_reg <= 9'h000;
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[7:0], pin_sync_reg[1]}; // [R01]
      end
   end

   // readiness of the word buffer seen by the host
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_word_ready <= 1'b0;
      end else begin
         o_word_ready <= fifo_in_ready;
      end
   end

   // words queue here while control words wait for a slot boundary
   word_fifo #(
      .WIDTH (vfd_scan_pkg::WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_word_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_resetn    (i_resetn),
      .i_in_valid  (load_rise), // [R01]
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (shift_reg),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_out_ready),
      .o_out_data  (fifo_out_data)
   );

   // drain stalls while a control word is pending
   assign fifo_out_ready = !pend_valid_reg; // [R23]

   // pending control word holder
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         pend_reg       <= 9'h000;
         pend_valid_reg <= 1'b0;
      end else if (apply) begin
         pend_valid_reg <= 1'b0;
      end else if (fifo_out_valid && fifo_out_ready && fifo_out_data[vfd_scan_pkg::KIND_BIT]) begin
         pend_reg       <= fifo_out_data; // [R02]
         pend_valid_reg <= 1'b1;
      end
   end

   // halted: apply at once; running: at slot end
   assign apply = pend_valid_reg && (state_reg == vfd_scan_pkg::SCAN_HALT || slot_end); // [R23]

   // display data store
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         for (int i = 0; i < vfd_scan_pkg::BUF_WORDS; i++) begin
            buf_mem[i] <= 8'h00;
         end
      end else if (fifo_out_valid && fifo_out_ready && !fifo_out_data[vfd_scan_pkg::KIND_BIT]
                   && !ptr_reg[4]) begin
         buf_mem[ptr_reg[3:0]] <= fifo_out_data[7:0]; // [R02]
      end
   end

   // pointer wraps when it reaches the digit count; 0 means 32
   assign ptr_inc = ptr_reg + 5'h01;

   // buffer pointer
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         ptr_reg <= vfd_scan_pkg::PTR_RST; // [R04]
      end else if (apply && pend_reg[7:4] == vfd_scan_pkg::PTR_PREFIX) begin
         ptr_reg <= pend_reg[4:0]; // [R05]
      end else if (fifo_out_valid && fifo_out_ready && !fifo_out_data[vfd_scan_pkg::KIND_BIT]) begin
         ptr_reg <= (ptr_inc == count_reg) ? 5'h00 : ptr_inc; // [R03]
      end
   end

   // digit count, duty and control registers
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         count_reg <= vfd_scan_pkg::COUNT_RST; // [R04]
         duty_reg  <= vfd_scan_pkg::DUTY_RST; // [R04]
         ctrl_reg  <= vfd_scan_pkg::CTRL_RST; // [R04] [R15]
      end else if (apply) begin
         if (pend_reg[7:5] == vfd_scan_pkg::COUNT_PREFIX) begin
            count_reg <= pend_reg[4:0]; // [R06]
         end
         if (pend_reg[7:6] == vfd_scan_pkg::DUTY_PREFIX) begin
            duty_reg <= pend_reg[5:0]; // [R12]
         end
         if (pend_reg[7:5] == vfd_scan_pkg::CTRL_PREFIX) begin
            ctrl_reg <= pend_reg[4:0]; // [R13]
         end
      end
   end

   // scan leaves halt on the first duty word
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         vfd_scan_pkg::SCAN_HALT: begin
            if (apply && pend_reg[7:6] == vfd_scan_pkg::DUTY_PREFIX) begin
               state_next = vfd_scan_pkg::SCAN_RUN;
            end
         end
         vfd_scan_pkg::SCAN_RUN: begin
            state_next = vfd_scan_pkg::SCAN_RUN;
         end
         default: begin
            state_next = vfd_scan_pkg::SCAN_HALT;
         end
      endcase
   end

   // scan state
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         state_reg <= vfd_scan_pkg::SCAN_HALT; // [R04]
      end else begin
         state_reg <= state_next;
      end
   end

   // internal cycle prescaler, half the internal clock period
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn || state_reg != vfd_scan_pkg::SCAN_RUN) begin
         tick_reg <= '0;
      end else if (cyc_tick) begin
         tick_reg <= '0;
      end else begin
         tick_reg <= tick_reg + 1'b1;
      end
   end

   // internal cycle tick, cycle length and slot end
   assign cyc_tick  = (tick_reg == TICK_LAST); // [R10]
   assign slot_last = slot_last_of(ctrl_reg[vfd_scan_pkg::TIME_LSB +: 2]); // [R10]
   assign slot_end  = cyc_tick && (cyc_reg == slot_last);

   // cycle position within the slot
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn || state_reg != vfd_scan_pkg::SCAN_RUN) begin
         cyc_reg <= 6'h00;
      end else if (slot_end) begin
         cyc_reg <= 6'h00;
      end else if (cyc_tick) begin
         cyc_reg <= cyc_reg + 6'h01;
      end
   end

   // slot index runs 0 up to the digit count minus one, then restarts
   assign slot_inc = slot_reg + 5'h01;

   // slot index register
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn || state_reg != vfd_scan_pkg::SCAN_RUN) begin
         slot_reg <= 5'h00;
      end else if (slot_end) begin
         slot_reg <= (slot_inc == count_reg) ? 5'h00 : slot_inc; // [R07] [R08]
      end
   end

   // on-time: duty minus two, at least zero, at most slot minus three
   always_comb begin
      on_time = (duty_reg > vfd_scan_pkg::DUTY_OFFSET) ?
                duty_reg - vfd_scan_pkg::DUTY_OFFSET : 6'h00; // [R12]
      if (on_time > slot_last - vfd_scan_pkg::OFF_CYCLES + 6'h01) begin
         on_time = slot_last - vfd_scan_pkg::OFF_CYCLES + 6'h01; // [R11]
      end
   end

   // drivers on only while running and inside the on-time
   assign drive_on = (state_reg == vfd_scan_pkg::SCAN_RUN) && (cyc_reg < on_time); // [R11]

   // word feeding the decoder for this slot
   assign dec_data = ctrl_reg[vfd_scan_pkg::CFG_BIT] ?
                     buf_mem[{slot_reg[2:0], 1'b1}] : buf_mem[slot_reg[3:0]]; // [R17] [R18]

   // glyph lookup or bypass doubling for the slot's word
   char_decoder #(
      .GLYPH_TABLE (GLYPH_TABLE)
   ) u_char_decoder (
      .i_mode     (ctrl_reg[vfd_scan_pkg::MODE_LSB +: 2]), // [R16]
      .i_data     (dec_data),
      .o_segments (dec_segments)
   );

   // one strobe per real slot, sixteen wide
   assign strobe16 = 16'h0001 << slot_reg[3:0];

   // driver pattern for the current slot
   always_comb begin
      grid_next   = 8'h00;
      direct_next = 8'h00;
      seg_next    = 16'h0000;
      if (drive_on) begin
         if (!ctrl_reg[vfd_scan_pkg::CFG_BIT]) begin
            if (!slot_reg[4]) begin // phantom slots stay dark [R09]
               grid_next   = strobe16[7:0]; // [R17]
               direct_next = strobe16[15:8]; // [R17]
               seg_next    = dec_segments; // [R17]
            end
         end else if (slot_reg[4:3] == 2'h0) begin
            grid_next   = strobe16[7:0]; // [R18]
            direct_next = buf_mem[{slot_reg[2:0], 1'b0}]; // [R18]
            seg_next    = dec_segments; // [R18]
         end
      end
   end

   // registered drivers, all off in reset and halt
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_grid_strobes            <= 8'h00; // [R04]
         o_direct_outputs          <= 8'h00; // [R04]
         o_decoded_segment_outputs <= 16'h0000; // [R04]
      end else begin
         o_grid_strobes            <= grid_next;
         o_direct_outputs          <= direct_next;
         o_decoded_segment_outputs <= seg_next;
      end
   end
endmodule : vfd_scan_control_decoder
`default_nettype wire

// >>> rtl/vfd_scan_pkg.sv
// constants, field layouts and types for the display scan controller
// assumes a 50 ns system clock; no import, every use is pkg::name
package vfd_scan_pkg;
   // word layout
   localparam int WORD_W   = 9;
   localparam int DATA_W   = 8;
   localparam int CTRL_W   = 5;
   localparam int DUTY_W   = 6;
   localparam int BUF_WORDS = 16;
   localparam int FIFO_WORDS = 8;
   localparam int KIND_BIT = 8;
   // control word prefixes, word bits 7 down
   localparam logic [1:0] DUTY_PREFIX  = 2'h1;
   localparam logic [2:0] COUNT_PREFIX = 3'h4;
   localparam logic [3:0] PTR_PREFIX   = 4'hC;
   localparam logic [2:0] CTRL_PREFIX  = 3'h0;
   // control register fields
   localparam int TIME_LSB = 0;
   localparam int CFG_BIT  = 2;
   localparam int MODE_LSB = 3;
   // reset values: 32 digits, 64 cycles, bypass, 16-digit
   localparam logic [4:0] PTR_RST   = 5'h00;
   localparam logic [4:0] COUNT_RST = 5'h00;
   localparam logic [5:0] DUTY_RST  = 6'h00;
   localparam logic [4:0] CTRL_RST  = 5'h00;
   // timing
   localparam int SYS_CLK_PERIOD_NS        = 50;
   localparam int INTERNAL_CLOCK_PERIOD_NS = 10000;
   localparam int CYCLE_TICKS = INTERNAL_CLOCK_PERIOD_NS / 2 / SYS_CLK_PERIOD_NS;
   localparam logic [5:0] OFF_CYCLES  = 6'h03;
   localparam logic [5:0] DUTY_OFFSET = 6'h02;
   // decoder modes
   typedef enum logic [1:0] {
      BYPASS_MODE          = 2'h0,
      RESERVED_MODE        = 2'h1,
      UPPER_CODE_HALF_MODE = 2'h2,
      LOWER_CODE_HALF_MODE = 2'h3
   } decoder_mode_t;
   // scan states, one-hot
   typedef enum logic [1:0] {
      SCAN_HALT = 2'h1,
      SCAN_RUN  = 2'h2
   } scan_state_t;
endpackage : vfd_scan_pkg

// >>> rtl/word_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_resetn,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      fill_reg;
   logic             push;
   logic             pop;

   // honest full and empty from the fill count
   assign o_in_ready  = (fill_reg != (AW+1)'(DEPTH));
   assign o_out_valid = (fill_reg != '0);
   assign o_out_data  = mem[rd_ptr_reg];
   assign push = i_in_valid && o_in_ready;
   assign pop  = o_out_valid && i_out_ready;

   // storage write
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= i_in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         fill_reg   <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (push && !pop) fill_reg <= fill_reg + 1'b1;
         else if (pop && !push) fill_reg <= fill_reg - 1'b1;
      end
   end
endmodule : word_fifo
`default_nettype wire

// >>> rtl/char_decoder.sv
// character decoder: bypass doubling or 64-code glyph lookup
// assumes glyph contents are supplied through GLYPH_TABLE
`timescale 1ns/100ps
`default_nettype none
module char_decoder #(
   parameter logic [128*14-1:0] GLYPH_TABLE = '0
) (
   input  wire logic [1:0]  i_mode,
   input  wire logic [7:0]  i_data,
   output logic      [15:0] o_segments
);
   logic [6:0] code;

   // upper half mode picks codes 64..127
   assign code = {i_mode == vfd_scan_pkg::UPPER_CODE_HALF_MODE, i_data[5:0]};

   // segment pattern per mode
   always_comb begin
      o_segments = 16'h0000;
      unique case (i_mode)
         vfd_scan_pkg::BYPASS_MODE: begin
            for (int n = 0; n < 8; n++) begin
               o_segments[2*n]   = i_data[n]; // [R19]
               o_segments[2*n+1] = i_data[n]; // [R19]
            end
         end
         vfd_scan_pkg::UPPER_CODE_HALF_MODE,
         vfd_scan_pkg::LOWER_CODE_HALF_MODE: begin
            o_segments[13:0]  = GLYPH_TABLE[code*14 +: 14]; // [R20]
            o_segments[15:14] = i_data[7:6]; // [R21]
         end
         vfd_scan_pkg::RESERVED_MODE: begin
            o_segments = 16'h0000; // undefined glyphs, shown blank
         end
      endcase
   end
endmodule : char_decoder
`default_nettype wire

// >>> tb/scan_monitor.sv
// checker on the top ports: reset state, one-hot strobes, on-time and off-time limits
// assumes binding onto vfd_scan_control_decoder with CYCLE_TICKS handed on
`timescale 1ns/100ps
`default_nettype none
module scan_monitor #(
   parameter int CYCLE_TICKS = 2
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic [7:0]  o_grid_strobes,
   input  wire logic [7:0]  o_direct_outputs,
   input  wire logic [15:0] o_decoded_segment_outputs,
   input  wire logic        o_word_ready
);
   logic        drv;
   logic        drv_q_reg;
   logic [15:0] off_cnt_reg;
   logic [15:0] on_cnt_reg;
   logic [15:0] since_rise_reg;
   default clocking cb @(posedge i_sys_clk); endclocking
   // any driver on
   assign drv = |{o_grid_strobes, o_direct_outputs, o_decoded_segment_outputs};
   // saturating run lengths of on time, off time and rise-to-rise time
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         drv_q_reg      <= 1'b0;
         off_cnt_reg    <= 16'hFFFF;
         on_cnt_reg     <= 16'h0000;
         since_rise_reg <= 16'hFFFF;
      end else begin
         drv_q_reg      <= drv;
         off_cnt_reg    <= drv ? 16'h0000 : (&off_cnt_reg ? off_cnt_reg : off_cnt_reg + 16'h0001);
         on_cnt_reg     <= !drv ? 16'h0000 : (&on_cnt_reg ? on_cnt_reg : on_cnt_reg + 16'h0001);
         since_rise_reg <= (drv && !drv_q_reg) ? 16'h0001 :
                           (&since_rise_reg ? since_rise_reg : since_rise_reg + 16'h0001);
      end
   end
   property p_reset_off;
      !i_resetn |=> !drv;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("drivers on after reset");
   property p_ready_reset;
      !i_resetn |=> !o_word_ready;
   endproperty
   a_ready_reset: assert property (p_ready_reset) else $error("ready during reset");
   property p_grid_onehot;
      disable iff (!i_resetn) $onehot0(o_grid_strobes);
   endproperty
   a_grid_onehot: assert property (p_grid_onehot) else $error("two grids at once");
   property p_no_jump;
      disable iff (!i_resetn)
      o_grid_strobes != 8'h00 |=> o_grid_strobes == $past(o_grid_strobes) || o_grid_strobes == 8'h00;
   endproperty
   a_no_jump: assert property (p_no_jump) else $error("strobe moved without off gap");
   property p_seg_strobe;
      disable iff (!i_resetn)
      o_decoded_segment_outputs != 16'h0000 |-> (o_grid_strobes | o_direct_outputs) != 8'h00;
   endproperty
   a_seg_strobe: assert property (p_seg_strobe) else $error("segments without strobe");
   property p_off_gap;
      disable iff (!i_resetn) drv && !drv_q_reg |-> off_cnt_reg >= 16'(3 * CYCLE_TICKS);
   endproperty
   a_off_gap: assert property (p_off_gap) else $error("off gap too short");
   property p_on_max;
      disable iff (!i_resetn) on_cnt_reg <= 16'(61 * CYCLE_TICKS);
   endproperty
   a_on_max: assert property (p_on_max) else $error("on time too long");
   property p_slot_min;
      disable iff (!i_resetn) drv && !drv_q_reg |-> since_rise_reg >= 16'(8 * CYCLE_TICKS);
   endproperty
   a_slot_min: assert property (p_slot_min) else $error("slot shorter than 8 cycles");
   // main scenarios
   c_rise: cover property (disable iff (!i_resetn) drv && !drv_q_reg);
   c_eight: cover property (disable iff (!i_resetn) o_grid_strobes != 8'h00 && o_direct_outputs != 8'h00);
   c_seg: cover property (disable iff (!i_resetn) o_decoded_segment_outputs[15:14] != 2'h0);
endmodule : scan_monitor
bind vfd_scan_control_decoder scan_monitor #(.CYCLE_TICKS(CYCLE_TICKS)) i_mon (
   .i_sys_clk                 (i_sys_clk),
   .i_resetn                  (i_resetn),
   .o_grid_strobes            (o_grid_strobes),
   .o_direct_outputs          (o_direct_outputs),
   .o_decoded_segment_outputs (o_decoded_segment_outputs),
   .o_word_ready              (o_word_ready)
);
`default_nettype wire

// >>> tb/host_link.sv
// host model: shifts nine-bit words onto the serial link, 400 ns bit clock
// assumes tick alignment to the system clock; waits for room before each word
`timescale 1ns/100ps
`default_nettype none
module host_link (
   input  wire logic i_sys_clk,
   input  wire logic i_word_ready,
   output logic      o_serial_clk,
   output logic      o_serial_data,
   output logic      o_word_load_strobe
);
   // link idles with clock low
   initial begin
      o_serial_clk       = 1'b0;
      o_serial_data      = 1'b0;
      o_word_load_strobe = 1'b0;
   end
   // n system clocks, then just past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : tick
   // one word msb first, then the load pulse
   task automatic send(input logic [8:0] w);
      int k;
      k = 0;
      tick(1);
      while (i_word_ready !== 1'b1 && k < 2000) begin
         tick(1);
         k++;
      end
      for (int b = 8; b >= 0; b--) begin
         o_serial_data = w[b];
         tick(4);
         o_serial_clk = 1'b1;
         tick(4);
         o_serial_clk = 1'b0;
      end
      o_serial_data = !w[0]; // released line never shows a stale bit
      tick(4);
      o_word_load_strobe = 1'b1;
      tick(8);
      o_word_load_strobe = 1'b0;
      tick(4);
   endtask : send
endmodule : host_link
`default_nettype wire

// >>> tb/tb.sv
// testbench: configures four display setups and checks every scan slot
// assumes CYCLE_TICKS of 2; glyph entry c of the table holds the value c
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int TICKS = 2;
   logic        i_sys_clk;
   logic        i_resetn;
   logic        s_clk;
   logic        s_dat;
   logic        s_load;
   logic [7:0]  grid;
   logic [7:0]  direct;
   logic [15:0] seg;
   logic        ready;
   logic [31:0] outs;
   logic [7:0]  buf_mem [16];
   int          n_mismatch;
   int          compares;
   int          cycles;
   // setups: control bits, digit count, duty; reserved decoder mode left out
   logic [4:0]  cfg_ctrl  [4] = '{5'h03, 5'h11, 5'h1E, 5'h00};
   logic [4:0]  cfg_count [4] = '{5'h03, 5'h12, 5'h08, 5'h00};
   logic [5:0]  cfg_duty  [4] = '{6'h07, 6'h3F, 6'h03, 6'h04};
   assign outs = {direct, grid, seg};
   host_link i_host (
      .i_sys_clk          (i_sys_clk),
      .i_word_ready       (ready),
      .o_serial_clk       (s_clk),
      .o_serial_data      (s_dat),
      .o_word_load_strobe (s_load)
   );
   // glyph c shows the code c itself, so the two code halves differ
   function automatic logic [128*14-1:0] glyphs();
      logic [128*14-1:0] g;
      g = '0;
      for (int c = 0; c < 128; c++) g[c*14 +: 14] = 14'(c);
      return g;
   endfunction : glyphs
   vfd_scan_control_decoder #(.CYCLE_TICKS(TICKS), .GLYPH_TABLE(glyphs())) i_dut (
      .i_sys_clk                 (i_sys_clk),
      .i_resetn                  (i_resetn),
      .i_serial_clk              (s_clk),
      .i_serial_data             (s_dat),
      .i_word_load_strobe        (s_load),
      .o_grid_strobes            (grid),
      .o_direct_outputs          (direct),
      .o_decoded_segment_outputs (seg),
      .o_word_ready              (ready)
   );
   // clock and hang guard
   initial i_sys_clk = 1'b0;
   always #25 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 80000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : tick
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   // segment pattern for one data byte
   function automatic logic [15:0] dec(input logic [1:0] m, input logic [7:0] d);
      logic [15:0] s;
      s = 16'h0000;
      if (m == 2'h0) for (int n = 0; n < 8; n++) s[2*n +: 2] = {2{d[n]}};
      else if (m[1]) s = {d[7:6], 7'h00, !m[0], d[5:0]}; // code half
      return s;
   endfunction : dec
   // driver outputs expected during the on-time of slot s
   function automatic logic [31:0] exp_out(input logic [4:0] c, input int s);
      logic [15:0] str;
      str = 16'h0000;
      if (!c[2] && s < 16) begin
         str[s] = 1'b1;
         return {str, dec(c[4:3], buf_mem[s])};
      end
      if (c[2] && s < 8) return {buf_mem[2*s], 8'h01 << s, dec(c[4:3], buf_mem[2*s+1])};
      return 32'h0;
   endfunction : exp_out
   // load one setup, fill the buffer, start and walk a full scan
   task automatic run_cfg(input int c);
      logic [4:0] ptr;
      logic [7:0] d;
      int         n;
      int         t;
      int         on;
      int         k;
      logic [31:0] e;
      ptr = 5'h00;
      n = (cfg_count[c] == 5'h00) ? 32 : int'(cfg_count[c]);
      t = (cfg_ctrl[c][1:0] == 2'h0) ? 64 : (cfg_ctrl[c][1:0] == 2'h1) ? 16 :
          (cfg_ctrl[c][1:0] == 2'h2) ? 32 : 8;
      on = (cfg_duty[c] < 6'h03) ? 0 : int'(cfg_duty[c]) - 2;
      if (on > t - 3) on = t - 3;
      i_host.send({4'h8, cfg_ctrl[c]});
      i_host.send({4'hC, cfg_count[c]});
      i_host.send(9'h1C0);
      i_host.send(9'h1D5);
      for (int i = 0; i < 20; i++) begin
         d = (i == 0) ? 8'hFF : 8'($urandom);
         i_host.send({1'b0, d});
         if (ptr < 5'h10) buf_mem[ptr[3:0]] = d;
         ptr = ptr + 5'h01;
         if (ptr == cfg_count[c]) ptr = 5'h00;
      end
      if (c == 0) check("halted", outs, 32'h0);
      i_host.send({3'h5, cfg_duty[c]});
      tick(2000);
      k = 0;
      while (grid[0] === 1'b1 && k < 20000) begin
         tick(1);
         k++;
      end
      while (grid[0] !== 1'b1 && k < 20000) begin
         tick(1);
         k++;
      end
      for (int s = 0; s <= n; s++) begin
         e = exp_out(cfg_ctrl[c], s % n);
         check("slot start", outs, e);
         tick(on * TICKS - 1);
         check("slot on end", outs, e);
         tick(1);
         check("slot off", outs, 32'h0);
         tick((t - on) * TICKS);
      end
   endtask : run_cfg
   // main sequence
   initial begin
      i_resetn   = 1'b0;
      n_mismatch = 0;
      compares   = 0;
      cycles     = 0;
      for (int i = 0; i < 16; i++) buf_mem[i] = 8'h00;
      void'($urandom(40));
      repeat (12) @(posedge i_sys_clk);
      #1;
      i_resetn = 1'b1;
      check("reset outputs", outs, 32'h0);
      tick(2);
      check("ready after reset", {31'h0, ready}, 32'h1);
      for (int c = 0; c < 4; c++) run_cfg(c);
      i_resetn = 1'b0;
      tick(2);
      check("mid reset outputs", outs, 32'h0);
      check("mid reset ready", {31'h0, ready}, 32'h0);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
